// File: src/supply_supervisor.sv
`default_nettype none
module supply_supervisor #(
  parameter int BLANK_LIM   = supervisor_pkg::BLANK_CYC,
  parameter int SLOW_LIM    = supervisor_pkg::DEG_SLOW_CYC,
  parameter int EXTRA_LIM   = supervisor_pkg::STROBE_EXTRA_CYC,
  parameter int REL_LIM0    = supervisor_pkg::REL_DLY0_CYC,
  parameter int REL_LIM1    = supervisor_pkg::REL_DLY1_CYC,
  parameter int REL_LIM2    = supervisor_pkg::REL_DLY2_CYC,
  parameter int REL_LIM3    = supervisor_pkg::REL_DLY3_CYC
) (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      srst,
  // configuration
  input  wire logic                      tight_mode,
  input  wire logic [1:0]                good_release_delay,
  // main rails: enables and comparators
  input  wire supervisor_pkg::rail_vec_t rail_enable,
  input  wire supervisor_pkg::rail_vec_t uv_raw,
  input  wire supervisor_pkg::rail_vec_t ov_raw,
  // sequencer status
  input  wire logic                      seq_done,
  input  wire logic                      powerdown_active,
  input  wire logic                      suspend_state,
  input  wire logic                      strobe_timer_done,
  input  wire supervisor_pkg::rail_vec_t strobe_rails,
  // backup rails
  input  wire logic                      backup_rail_a_good,
  input  wire logic                      backup_rail_b_good,
  // open-drain main good pin
  output logic                           main_rails_good_out,
  output logic                           main_rails_good_oe,
  // other outputs
  output logic                           backup_rails_good,
  output logic                           fault_powerdown_req,
  output logic                           strobe_proceed,
  output supervisor_pkg::rail_vec_t      rail_fault,
  output supervisor_pkg::permil_t        uv_limit [supervisor_pkg::NUM_RAILS],
  output supervisor_pkg::permil_t        ov_limit [supervisor_pkg::NUM_RAILS]
);
  import supervisor_pkg::*;

  rail_vec_t     monitoring;
  rail_vec_t     filt_fault;
  rail_vec_t     active_fault;
  logic          any_fault;
  logic          fault_seen;
  logic          all_watched;
  logic          force_low;
  pg_state_t     pg_state;
  cnt_t          rel_cnt;
  strobe_state_t st_state;
  cnt_t          extra_cnt;
  logic          strobe_good;

  // release delay code to cycle count
  function automatic cnt_t rel_cycles(input logic [1:0] code);
    case (code)
      2'h0:    rel_cycles = cnt_t'(REL_LIM0);
      2'h1:    rel_cycles = cnt_t'(REL_LIM1);
      2'h2:    rel_cycles = cnt_t'(REL_LIM2);
      default: rel_cycles = cnt_t'(REL_LIM3);
    endcase
  endfunction

  // buck one and two carry the narrower window
  function automatic permil_t pick(input int rail, input permil_t b12,
                                   input permil_t other);
    pick = (rail == RAIL_BUCK_ONE || rail == RAIL_BUCK_TWO) ? b12 : other;
  endfunction

  // ----------------------------------------------------------------
  // per-rail filters and limit selection
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NUM_RAILS; i++) begin : g_rail
    rail_filter #(
      .BLANK_LIM (BLANK_LIM),
      .SLOW_LIM  (SLOW_LIM)
    ) u_filt (
      .clk        (clk),
      .srst       (srst),
      .enable     (rail_enable[i]),
      .tight      (tight_mode),
      .uv_raw     (uv_raw[i]),
      .ov_raw     (ov_raw[i]),
      .monitoring (monitoring[i]),
      .fault      (filt_fault[i])
    );

    // thresholds handed to the analog comparators
    always_ff @(posedge clk) begin
      if (srst) begin
        uv_limit[i] <= UV_RELAXED_PM;
        ov_limit[i] <= OV_NONE_PM;
      end else if (tight_mode) begin
        uv_limit[i] <= pick(i, UV_TIGHT_B12, UV_TIGHT_OTHER);
        ov_limit[i] <= pick(i, OV_TIGHT_B12, OV_TIGHT_OTHER);
      end else begin
        uv_limit[i] <= UV_RELAXED_PM;
        ov_limit[i] <= OV_NONE_PM;
      end
    end
  end

  // ----------------------------------------------------------------
  // good / fault decision
  // ----------------------------------------------------------------
  // a disabled rail drops out; filter flags clear with the enable
  assign active_fault = filt_fault & monitoring & rail_enable;
  assign any_fault    = |active_fault;
  assign all_watched  = ((monitoring | ~rail_enable) == '1);
  assign force_low    = powerdown_active || suspend_state
                        || (rail_enable == '0) || any_fault;
  assign rail_fault   = active_fault;

  // one request per fault episode, not one per cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      fault_seen          <= 1'b0;
      fault_powerdown_req <= 1'b0;
    end else begin
      fault_seen          <= any_fault;
      fault_powerdown_req <= any_fault && !fault_seen;
    end
  end

  // main good state; a rail enable dropping alone pulls it low only when no rail is left enabled
  always_ff @(posedge clk) begin
    if (srst) begin
      pg_state <= PG_LOW;
      rel_cnt  <= CNT_ZERO;
    end else if (force_low) begin
      pg_state <= PG_LOW;
      rel_cnt  <= CNT_ZERO;
    end else begin
      case (pg_state)
        PG_LOW: begin
          if (seq_done && all_watched) begin
            pg_state <= PG_DELAY;
            rel_cnt  <= CNT_ZERO;
          end
        end
        PG_DELAY: begin
          if (!seq_done) pg_state <= PG_LOW;
          else if (rel_cnt >= rel_cycles(good_release_delay) - CNT_ONE)
            pg_state <= PG_HIGH;
          else rel_cnt <= rel_cnt + CNT_ONE;
        end
        PG_HIGH: pg_state <= PG_HIGH;
        default: pg_state <= PG_LOW;
      endcase
    end
  end

  // open drain: pull low unless high, never drive high
  assign main_rails_good_out = 1'b0;
  assign main_rails_good_oe  = (pg_state != PG_HIGH);

  // backup good is a plain gate, no filtering and no side effects
  assign backup_rails_good = backup_rail_a_good
                             & backup_rail_b_good;

  // ----------------------------------------------------------------
  // strobe hold for slow rails
  // ----------------------------------------------------------------
  assign strobe_good = ((strobe_rails & uv_raw) == '0);

  always_ff @(posedge clk) begin
    if (srst) begin
      st_state       <= ST_IDLE;
      extra_cnt      <= CNT_ZERO;
      strobe_proceed <= 1'b0;
    end else begin
      strobe_proceed <= 1'b0;
      case (st_state)
        ST_IDLE: begin
          if (strobe_timer_done && strobe_good) strobe_proceed <= 1'b1;
          else if (strobe_timer_done) st_state <= ST_WAIT_GOOD;
        end
        ST_WAIT_GOOD: begin
          extra_cnt <= CNT_ZERO;
          if (strobe_good) st_state <= ST_EXTRA;
        end
        ST_EXTRA: begin
          if (extra_cnt >= cnt_t'(EXTRA_LIM - 1)) begin
            st_state       <= ST_IDLE;
            strobe_proceed <= 1'b1;
          end else extra_cnt <= extra_cnt + CNT_ONE;
        end
        default: st_state <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_fault_drops_pin: assert property (@(posedge clk) disable iff (srst)
    any_fault |=> main_rails_good_oe)
    else $error("pin released during qualified fault");
  a_fault_request: assert property (@(posedge clk) disable iff (srst)
    $rose(any_fault) |=> fault_powerdown_req ##1 !fault_powerdown_req)
    else $error("power-down request missing or stuck");
  a_none_enabled: assert property (@(posedge clk) disable iff (srst)
    rail_enable == '0 |=> main_rails_good_oe)
    else $error("pin released with no rail enabled");
  a_powerdown_low: assert property (@(posedge clk) disable iff (srst)
    powerdown_active |=> main_rails_good_oe)
    else $error("pin released during power-down");
  a_suspend_low: assert property (@(posedge clk) disable iff (srst)
    suspend_state |=> main_rails_good_oe)
    else $error("pin released in suspend");
  // cycles spent in the release delay, so the check follows the code
  cnt_t delay_age;
  always_ff @(posedge clk) begin
    if (srst || pg_state != PG_DELAY) delay_age <= CNT_ZERO;
    else delay_age <= delay_age + CNT_ONE;
  end

  a_release_delay: assert property (@(posedge clk) disable iff (srst)
    $fell(main_rails_good_oe) |-> delay_age == rel_cycles(good_release_delay))
    else $error("pin released before or after release delay");
  a_backup_and: assert property (@(posedge clk) disable iff (srst)
    backup_rails_good == (backup_rail_a_good && backup_rail_b_good))
    else $error("backup good not the and of both");
  a_backup_isolated: assert property (@(posedge clk)
    disable iff (srst)
    $fell(backup_rails_good) && !any_fault |=> !fault_powerdown_req)
    else $error("backup fault requested power-down");
  a_strobe_hold: assert property (@(posedge clk) disable iff (srst)
    st_state == ST_WAIT_GOOD && !strobe_good |=> !strobe_proceed)
    else $error("strobe advanced while rail not good");
endmodule // supply_supervisor
`default_nettype wire

// File: src/supervisor_pkg.sv
`default_nettype none
package supervisor_pkg;
  // ----------------------------------------------------------------
  // rails and clock
  // ----------------------------------------------------------------
  localparam int NUM_RAILS       = 5;
  localparam int RAIL_BUCK_ONE   = 0;
  localparam int RAIL_BUCK_TWO   = 1;
  localparam int CLK_HZ          = 25_000_000;
  localparam int CNT_W           = 20;
  typedef logic [CNT_W-1:0] cnt_t;
  typedef logic [NUM_RAILS-1:0] rail_vec_t;
  localparam cnt_t CNT_ZERO      = 20'h00000;
  localparam cnt_t CNT_ONE       = 20'h00001;

  // ----------------------------------------------------------------
  // timing, printed units, then cycles
  // ----------------------------------------------------------------
  localparam int BLANK_MS        = 5;
  localparam int DEG_SLOW_MS     = 1;
  localparam int DEG_FAST_US     = 50;
  localparam int DEG_RISE_US     = 10;
  localparam int STROBE_EXTRA_MS = 1;
  localparam int BLANK_CYC       = BLANK_MS * (CLK_HZ / 1000);
  localparam int DEG_SLOW_CYC    = DEG_SLOW_MS * (CLK_HZ / 1000);
  localparam int DEG_FAST_CYC    = DEG_FAST_US * (CLK_HZ / 1000000);
  localparam int DEG_RISE_CYC    = DEG_RISE_US * (CLK_HZ / 1000000);
  localparam int STROBE_EXTRA_CYC = STROBE_EXTRA_MS * (CLK_HZ / 1000);

  // release delay choices in ms (plain defaults)
  localparam int REL_DLY0_MS     = 1;
  localparam int REL_DLY1_MS     = 2;
  localparam int REL_DLY2_MS     = 5;
  localparam int REL_DLY3_MS     = 10;
  localparam int REL_DLY0_CYC    = REL_DLY0_MS * (CLK_HZ / 1000);
  localparam int REL_DLY1_CYC    = REL_DLY1_MS * (CLK_HZ / 1000);
  localparam int REL_DLY2_CYC    = REL_DLY2_MS * (CLK_HZ / 1000);
  localparam int REL_DLY3_CYC    = REL_DLY3_MS * (CLK_HZ / 1000);

  // ----------------------------------------------------------------
  // comparator limits in tenths of a percent
  // ----------------------------------------------------------------
  typedef logic [9:0] permil_t;
  localparam permil_t UV_RELAXED_PM  = 10'h384;  // 90.0 %, plain default
  localparam permil_t UV_TIGHT_B12   = 10'h3c5;  // 96.5 %
  localparam permil_t UV_TIGHT_OTHER = 10'h3bb;  // 95.5 %
  localparam permil_t OV_TIGHT_B12   = 10'h40b;  // 1.1 %: 10'h40b is truncated to 10 bits, leaving 10'h00b
  localparam permil_t OV_TIGHT_OTHER = 10'h415;  // 2.1 %: 10'h415 is truncated to 10 bits, leaving 10'h015
  localparam permil_t OV_NONE_PM     = 10'h000;  // no check

  typedef enum {PG_LOW, PG_DELAY, PG_HIGH} pg_state_t;
  typedef enum {ST_IDLE, ST_WAIT_GOOD, ST_EXTRA} strobe_state_t;
endpackage
`default_nettype wire

// File: src/rail_filter.sv
`default_nettype none
// ------------------------------------------------------------------
// one rail: blanking after enable, deglitched under/over voltage
// ------------------------------------------------------------------
module rail_filter #(
  parameter int BLANK_LIM = supervisor_pkg::BLANK_CYC,
  parameter int SLOW_LIM  = supervisor_pkg::DEG_SLOW_CYC
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // rail controls and comparators
  input  wire logic enable,
  input  wire logic tight,
  input  wire logic uv_raw,
  input  wire logic ov_raw,
  // qualified state
  output logic      monitoring,
  output logic      fault
);
  import supervisor_pkg::*;

  cnt_t blank_cnt;
  cnt_t uv_cnt;
  cnt_t ov_cnt;
  logic uv_fault;
  logic ov_fault;
  cnt_t uv_lim;
  cnt_t ov_lim;

  // blanking restarts on every disable so each enable gets full time
  always_ff @(posedge clk) begin
    if (srst || !enable) begin
      blank_cnt  <= CNT_ZERO;
      monitoring <= 1'b0;
    end else if (!monitoring) begin
      if (blank_cnt == cnt_t'(BLANK_LIM - 1)) monitoring <= 1'b1;
      blank_cnt <= blank_cnt + CNT_ONE;
    end
  end

  // deglitch lengths depend on mode and on direction
  always_comb begin
    if (uv_fault) uv_lim = cnt_t'(DEG_RISE_CYC);
    else if (tight) uv_lim = cnt_t'(DEG_FAST_CYC);
    else uv_lim = cnt_t'(SLOW_LIM);
    ov_lim = ov_fault ? cnt_t'(SLOW_LIM) : cnt_t'(DEG_FAST_CYC);
  end

  // counter runs only while comparator disagrees with the flag
  always_ff @(posedge clk) begin
    if (srst || !monitoring) begin
      uv_cnt   <= CNT_ZERO;
      uv_fault <= 1'b0;
    end else if (uv_raw == uv_fault) begin
      uv_cnt <= CNT_ZERO;
    end else if (uv_cnt >= uv_lim - CNT_ONE) begin
      uv_cnt   <= CNT_ZERO;
      uv_fault <= uv_raw;
    end else begin
      uv_cnt <= uv_cnt + CNT_ONE;
    end
  end

  // overvoltage only watched in tight mode
  always_ff @(posedge clk) begin
    if (srst || !monitoring || !tight) begin
      ov_cnt   <= CNT_ZERO;
      ov_fault <= 1'b0;
    end else if (ov_raw == ov_fault) begin
      ov_cnt <= CNT_ZERO;
    end else if (ov_cnt >= ov_lim - CNT_ONE) begin
      ov_cnt   <= CNT_ZERO;
      ov_fault <= ov_raw;
    end else begin
      ov_cnt <= ov_cnt + CNT_ONE;
    end
  end

  assign fault = uv_fault | ov_fault;

  a_uv_fast_qual: assert property (@(posedge clk) disable iff (srst)
    monitoring && tight && !uv_fault && uv_raw && !$past(uv_fault)
    && uv_cnt == cnt_t'(DEG_FAST_CYC - 1) |=> uv_fault)
    else $error("tight undervoltage not qualified on time");
  a_no_ov_relaxed: assert property (@(posedge clk) disable iff (srst)
    !tight |=> !ov_fault)
    else $error("overvoltage flagged in relaxed mode");
  a_blank_hold: assert property (@(posedge clk) disable iff (srst)
    $rose(enable) |-> !monitoring [*8])
    else $error("monitoring started before blanking");
endmodule // rail_filter
`default_nettype wire

// File: test/sequencer_model.sv
`default_nettype none
// ------------------------------------------------------------------
// power sequencer seen from the supervisor
// ------------------------------------------------------------------
module sequencer_model #(
  parameter int STROBE_DLY = 6
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // from the supervisor
  input  wire logic fault_powerdown_req,
  // bench commands
  input  wire logic strobe_go,
  input  wire logic pd_clear,
  // to the supervisor
  output logic      powerdown_active,
  output logic      strobe_timer_done
);
  timeunit 1ns;
  timeprecision 1ns;
  int dly;

  // a qualified fault runs power-down until the bench ends it
  always_ff @(posedge clk) begin
    if (srst || pd_clear) powerdown_active <= 1'b0;
    else if (fault_powerdown_req) powerdown_active <= 1'b1;
  end

  // strobe delay timer, one pulse per request, never free running
  always_ff @(posedge clk) begin
    strobe_timer_done <= 1'b0;
    if (srst) dly <= 0;
    else if (strobe_go && dly == 0) dly <= 1;
    else if (dly == STROBE_DLY) begin
      dly <= 0;
      strobe_timer_done <= 1'b1;
    end else if (dly != 0) dly <= dly + 1;
  end
endmodule // sequencer_model
`default_nettype wire

// File: test/supply_supervisor_tb_top.sv
`default_nettype none
module supply_supervisor_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import supervisor_pkg::*;
  // short counts keep the run small; the tight windows stay real
  localparam int BLANK = 20;
  localparam int SLOW  = 40;
  localparam int EXTRA = 10;
  localparam int REL [4] = '{5, 8, 12, 16};
  logic      clk = 1'b0, srst = 1'b1, tight_mode = 1'b0, seq_done = 1'b0;
  logic      suspend_state = 1'b0, strobe_go = 1'b0, pd_clear = 1'b0;
  logic      backup_rail_a_good = 1'b0, backup_rail_b_good = 1'b0;
  logic [1:0] good_release_delay = 2'h0;
  rail_vec_t rail_enable = 5'h00, uv_raw = 5'h00, ov_raw = 5'h00;
  rail_vec_t strobe_rails = 5'h00, rail_fault;
  logic      main_rails_good_out, main_rails_good_oe, backup_rails_good;
  logic      fault_powerdown_req, strobe_proceed, powerdown_active;
  logic      strobe_timer_done, cpu_reset_n;
  permil_t   uv_limit [NUM_RAILS], ov_limit [NUM_RAILS];
  int        num_errors = 0, tests_run = 0, cycles = 0, proceeds = 0;
  int        k, m, n;
  integer    seed = 32'he57e;

  // processor reset input has a pull-up behind the open-drain pin
  assign cpu_reset_n = main_rails_good_oe ? main_rails_good_out : 1'b1;
  always #20 clk = ~clk;

  supply_supervisor #(.BLANK_LIM(BLANK), .SLOW_LIM(SLOW),
    .EXTRA_LIM(EXTRA), .REL_LIM0(REL[0]), .REL_LIM1(REL[1]),
    .REL_LIM2(REL[2]), .REL_LIM3(REL[3])) dut_u (
    .clk(clk), .srst(srst), .tight_mode(tight_mode),
    .good_release_delay(good_release_delay), .rail_enable(rail_enable),
    .uv_raw(uv_raw), .ov_raw(ov_raw), .seq_done(seq_done),
    .powerdown_active(powerdown_active), .suspend_state(suspend_state),
    .strobe_timer_done(strobe_timer_done), .strobe_rails(strobe_rails),
    .backup_rail_a_good(backup_rail_a_good),
    .backup_rail_b_good(backup_rail_b_good),
    .main_rails_good_out(main_rails_good_out),
    .main_rails_good_oe(main_rails_good_oe),
    .backup_rails_good(backup_rails_good),
    .fault_powerdown_req(fault_powerdown_req),
    .strobe_proceed(strobe_proceed), .rail_fault(rail_fault),
    .uv_limit(uv_limit), .ov_limit(ov_limit));

  sequencer_model seq_u (
    .clk(clk), .srst(srst), .fault_powerdown_req(fault_powerdown_req),
    .strobe_go(strobe_go), .pd_clear(pd_clear),
    .powerdown_active(powerdown_active),
    .strobe_timer_done(strobe_timer_done));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // cycle ceiling well above the whole sequence; counts pulses too
  always @(posedge clk) begin
    cycles++;
    if (strobe_proceed === 1'b1) proceeds++;
    if (cycles == 20000) begin
      num_errors++;
      summarize();
    end
  end

  task automatic tick(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_lim(input permil_t got, input permil_t exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // bounded wait for the pin level; limit keeps a hang visible
  task automatic wait_pin(input logic lvl, input int lim);
    n = 0;
    while (cpu_reset_n !== lvl && n < lim) begin
      tick(1);
      n++;
    end
  endtask

  function automatic permil_t exp_uv(input int r, input logic t);
    if (!t) return UV_RELAXED_PM;
    return (r <= RAIL_BUCK_TWO) ? UV_TIGHT_B12 : UV_TIGHT_OTHER;
  endfunction

  function automatic permil_t exp_ov(input int r, input logic t);
    if (!t) return OV_NONE_PM;
    return (r <= RAIL_BUCK_TWO) ? OV_TIGHT_B12 : OV_TIGHT_OTHER;
  endfunction

  task automatic summarize();
    $display("errors %0d of %0d compares", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    tick(20);
    srst = 1'b0;
    tick(1);
    chk_bit(cpu_reset_n, 1'b0);
    for (k = 0; k < NUM_RAILS; k++) begin
      chk_lim(uv_limit[k], exp_uv(k, 1'b0));
      chk_lim(ov_limit[k], exp_ov(k, 1'b0));
    end
    seq_done = 1'b1;
    tick(30);
    chk_bit(cpu_reset_n, 1'b0);
    // every release delay, blanking first, then drop on last disable
    for (k = 0; k < 4; k++) begin
      good_release_delay = 2'(k);
      rail_enable = 5'h1f;
      tick(BLANK + REL[k] - 2);
      chk_bit(cpu_reset_n, 1'b0);
      wait_pin(1'b1, 8);
      chk_bit(cpu_reset_n, 1'b1);
      rail_enable = 5'h00;
      tick(3);
      chk_bit(cpu_reset_n, 1'b0);
    end
    good_release_delay = 2'h0;
    rail_enable = 5'h1f;
    tick(BLANK + 3);
    // sequencer drops out inside the delay: delay must start over
    seq_done = 1'b0;
    tick(1);
    seq_done = 1'b1;
    tick(REL[0] - 1);
    chk_bit(cpu_reset_n, 1'b0);
    wait_pin(1'b1, 8);
    chk_bit(cpu_reset_n, 1'b1);
    // backup flags: AND, no effect on main pin
    repeat (8) begin
      {backup_rail_a_good, backup_rail_b_good} = 2'($random(seed));
      #1;
      chk_bit(backup_rails_good,
              backup_rail_a_good & backup_rail_b_good);
      tick(2);
      chk_bit(cpu_reset_n, 1'b1);
    end
    // short random dips restart the filter, relaxed ignores overvoltage
    repeat (4) begin
      k = {$random(seed)} % NUM_RAILS;
      uv_raw[k] = 1'b1;
      tick(1 + {$random(seed)} % (SLOW - 5));
      uv_raw[k] = 1'b0;
      tick(2);
      chk_bit(rail_fault[k], 1'b0);
    end
    ov_raw = 5'h1f;
    tick(SLOW + 20);
    chk_bit(cpu_reset_n, 1'b1);
    ov_raw = 5'h00;
    // disabled rail is ignored and its disable leaves the pin alone
    rail_enable = 5'h0f;
    uv_raw[4] = 1'b1;
    tick(SLOW + 10);
    chk_bit(cpu_reset_n, 1'b1);
    uv_raw[4] = 1'b0;
    rail_enable = 5'h1f;
    tick(BLANK + 4);
    suspend_state = 1'b1;
    tick(3);
    chk_bit(cpu_reset_n, 1'b0);
    suspend_state = 1'b0;
    wait_pin(1'b1, REL[0] + 8);
    // relaxed then tight faults: undervoltage, then overvoltage
    for (m = 0; m < 3; m++) begin
      tight_mode = (m != 0);
      tick(3);
      for (k = 0; k < NUM_RAILS; k++) begin
        chk_lim(uv_limit[k], exp_uv(k, tight_mode));
        chk_lim(ov_limit[k], exp_ov(k, tight_mode));
      end
      n = (m == 0) ? SLOW : DEG_FAST_CYC;
      k = {$random(seed)} % NUM_RAILS;
      if (m == 2) ov_raw[k] = 1'b1;
      else uv_raw[k] = 1'b1;
      tick(n - 5);
      chk_bit(rail_fault[k], 1'b0);
      wait_pin(1'b0, 12);
      chk_bit(cpu_reset_n, 1'b0);
      chk_bit(rail_fault[k], 1'b1);
      // request pulse, then the sequencer latches power-down
      tick(2);
      chk_bit(powerdown_active, 1'b1);
      uv_raw = 5'h00;
      ov_raw = 5'h00;
      n = (m == 2) ? SLOW : DEG_RISE_CYC;
      tick(n - 5);
      chk_bit(rail_fault[k], 1'b1);
      tick(10);
      chk_bit(rail_fault[k], 1'b0);
      chk_bit(cpu_reset_n, 1'b0);
      pd_clear = 1'b1;
      tick(1);
      pd_clear = 1'b0;
      wait_pin(1'b1, REL[0] + 8);
      chk_bit(cpu_reset_n, 1'b1);
    end
    // strobe: late rail holds the next strobe, then the extra wait
    tight_mode = 1'b0;
    rail_enable = 5'h1e;
    strobe_rails = 5'h01;
    uv_raw[0] = 1'b1;
    strobe_go = 1'b1;
    tick(1);
    strobe_go = 1'b0;
    m = proceeds;
    tick(30);
    chk_bit(proceeds == m, 1'b1);
    uv_raw[0] = 1'b0;
    tick(EXTRA - 2);
    chk_bit(proceeds == m, 1'b1);
    tick(6);
    chk_bit(proceeds == m + 1, 1'b1);
    strobe_go = 1'b1;
    tick(1);
    strobe_go = 1'b0;
    tick(12);
    chk_bit(proceeds == m + 2, 1'b1);
    summarize();
  end
endmodule // supply_supervisor_tb_top
`default_nettype wire
